// ---- src/lbsc_pkg.sv ----
/*
 contents: constants, register map and carrier types of the sync control block.
 assumes: one 100 MHz clock, software on AXI4-Lite, a raw bus pin on its own timing.
*/
// Contract
// - lin mode, gate set: uart receive held high until break and sync seen
// - lin mode, gate clear: receive line passed to uart at all times, no break or sync needed
// - bus read mode, gate set: each rising edge sets break status bit 0
// - bus read mode: break timer starts at falling edge, stops at rising
// - bus read mode: break timer flags compare match and overflow too
// - bus write mode: compare status bit 3 tells when to release bus
// - bus write mode: break timer stops at rising edge to check pulses
// - control bit 7 picks falling or rising edge count stopping sync timer
// - control bit 6 picks lin mode (0) or pulse bus mode (1)
// - control bit 5 clear: no sync compare status (bit 3); break compare still sets bit 0
// - control bit 5 set: sync timer equal to compare sets status bit 3
package lbsc_pkg;
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] OFS_CTRL0 = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_CTRL1 = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_MASK = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_BRK_TMR = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_SYNC_TMR = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_SYNC_CMP = 8'h18;
    localparam int CTRL0_W = 14;
    localparam logic [CTRL0_W-1:0] CTRL0_RST = 14'h0000;
    localparam logic [3:0] CTRL1_RST = 4'h0;
    localparam int ST_BRK = 0;
    localparam int ST_OVF = 1;
    localparam int ST_SYNC = 2;
    localparam int ST_CMP = 3;
    localparam int ST_W = 4;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam int TMR_W = 16;

    // control word 0 as stored; bit 13 is the write sub-mode
    typedef struct packed {
        logic bus_write_mode;
        logic [3:0] unused_hi;
        logic gate;
        logic stop_on_rise;
        logic bus_mode;
        logic cmp_en;
        logic [1:0] unused_lo;
        logic enable;
        logic [1:0] unused_0;
    } lbsc_ctrl0_s;

    typedef struct packed {
        logic fall;
        logic rise;
        logic level;
    } lbsc_line_s;
endpackage

// ---- src/lbsc_top.sv ----
/*
 holds the whole sync control block: register slave, pin synchroniser,
 break timer, sync bit timer, uart receive gating and interrupt status.
 assumes: bus_rx is asynchronous; AXI4-Lite master keeps one write and one read at a time.
*/
module lbsc_top
    import lbsc_pkg::*;
#(
    parameter int TMR_BITS = TMR_W
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic bus_rx,
    output logic uart_rxd,
    output logic irq
);
    function automatic logic mapped(input logic [ADDR_W-1:0] a);
        return a == OFS_CTRL0 || a == OFS_CTRL1 || a == OFS_STATUS || a == OFS_MASK
            || a == OFS_BRK_TMR || a == OFS_SYNC_TMR || a == OFS_SYNC_CMP;
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
        input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
                r[8*i +: 8] = nw[8*i +: 8];
        end
        return r;
    endfunction

    typedef enum logic [1:0] {LBSC_IDLE, LBSC_BREAK, LBSC_SYNC, LBSC_DATA} lbsc_lin_e;

    lbsc_ctrl0_s ctrl0;
    logic [3:0] edge_target;
    logic [ST_W-1:0] status;
    logic [ST_W-1:0] mask;
    logic [TMR_BITS-1:0] brk_val;
    logic [TMR_BITS-1:0] brk_cmp;
    logic [TMR_BITS-1:0] sync_val;
    logic [TMR_BITS-1:0] sync_cmp;
    logic brk_run;
    logic sync_run;
    logic [3:0] edge_cnt;
    lbsc_lin_e lin_st;
    logic rx_s1;
    logic rx_s2;
    logic rx_s3;
    logic line_lvl;
    lbsc_line_s line;
    logic aw_full;
    logic w_full;
    logic [ADDR_W-1:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;

    // pin synchroniser: a change counts once the second and third agree
    always_ff @(posedge aclk)
    begin
        rx_s1 <= bus_rx;
        rx_s2 <= rx_s1;
        rx_s3 <= rx_s2;
        if (!aresetn)
            line_lvl <= 1'b1;
        else if (rx_s2 == rx_s3)
            line_lvl <= rx_s3;
    end

    wire agree = (rx_s2 == rx_s3);
    assign line.level = line_lvl;
    assign line.fall = agree && !rx_s3 && line_lvl;
    assign line.rise = agree && rx_s3 && !line_lvl;

    // mode decode: one stored gate bit, two meanings (lin and bus read), unused in bus write mode
    wire lin_mode = !ctrl0.bus_mode;
    wire bsd_read = ctrl0.bus_mode && !ctrl0.bus_write_mode;
    wire active = ctrl0.enable;

    // break timer: starts on falling edge, stops on rising edge in every mode
    wire brk_start = active && line.fall;
    wire brk_stop = line.rise;
    wire brk_tick = active && brk_run && !brk_stop;
    wire [TMR_BITS-1:0] brk_inc = brk_val + 1'b1;
    wire brk_hit = brk_tick && (brk_inc == brk_cmp);
    wire brk_ovf = brk_tick && (brk_val == {TMR_BITS{1'b1}});

    // sync edge counting: selected edge type ends the sync timer
    wire sel_edge = ctrl0.stop_on_rise ? line.rise : line.fall;
    wire sync_stop = sync_run && sel_edge && (edge_cnt + 4'h1 == edge_target);
    wire sync_start = active && line.fall && !sync_run
        && (ctrl0.bus_mode || lin_st == LBSC_SYNC);
    wire sync_tick = active && sync_run && !sync_stop;
    wire [TMR_BITS-1:0] sync_inc = sync_val + 1'b1;
    wire cmp_hit = sync_tick && (sync_inc == sync_cmp) && ctrl0.cmp_en;

    // status events
    // rise break in read mode
    wire rise_brk_ev = bsd_read && ctrl0.gate && line.rise;
    wire [ST_W-1:0] events = {cmp_hit, sync_stop && lin_mode, brk_ovf, brk_hit || rise_brk_ev};

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            brk_run <= 1'b0;
            brk_val <= '0;
        end
        else if (brk_start)
        begin
            brk_run <= 1'b1;
            brk_val <= '0;
        end
        else
        begin
            brk_run <= brk_run && !brk_stop && active;
            if (brk_tick)
                brk_val <= brk_inc;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sync_run <= 1'b0;
            sync_val <= '0;
            edge_cnt <= '0;
        end
        else if (sync_start)
        begin
            sync_run <= 1'b1;
            sync_val <= '0;
            edge_cnt <= '0;
        end
        else
        begin
            sync_run <= sync_run && !sync_stop && active;
            if (sync_tick)
                sync_val <= sync_inc;
            if (sync_run && sel_edge)
                edge_cnt <= edge_cnt + 4'h1;
        end
    end

    // lin frame tracking: break by compare hit, then sync byte edges
    always_ff @(posedge aclk)
    begin
        if (!aresetn || !active || !lin_mode)
            lin_st <= LBSC_IDLE;
        else
        begin
            case (lin_st)
                LBSC_IDLE: if (brk_hit) lin_st <= LBSC_BREAK;
                LBSC_BREAK: if (line.rise) lin_st <= LBSC_SYNC;
                LBSC_SYNC: if (sync_stop) lin_st <= LBSC_DATA;
                LBSC_DATA: if (brk_hit) lin_st <= LBSC_BREAK;
                default: lin_st <= LBSC_IDLE;
            endcase
        end
    end

    wire rx_hold = lin_mode && ctrl0.gate && (lin_st != LBSC_DATA);
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            uart_rxd <= 1'b1;
        else
            uart_rxd <= rx_hold ? 1'b1 : line_lvl;
    end

    // register slave
    wire do_write = aw_full && w_full && !s_axi_bvalid;
    wire rd_take = s_axi_arvalid && s_axi_arready;
    wire rd_status = rd_take && (s_axi_araddr == OFS_STATUS);
    assign s_axi_awready = !aw_full;
    assign s_axi_wready = !w_full;
    assign s_axi_arready = !s_axi_rvalid;

    wire [31:0] rd_mux =
        (s_axi_araddr == OFS_CTRL0) ? {{(32-CTRL0_W){1'b0}}, ctrl0} :
        (s_axi_araddr == OFS_CTRL1) ? {24'h000000, edge_target, 4'h0} :
        (s_axi_araddr == OFS_STATUS) ? {{(32-ST_W){1'b0}}, status} :
        (s_axi_araddr == OFS_MASK) ? {{(32-ST_W){1'b0}}, mask} :
        (s_axi_araddr == OFS_BRK_TMR) ? 32'(brk_val) :
        (s_axi_araddr == OFS_SYNC_TMR) ? 32'(sync_val) :
        (s_axi_araddr == OFS_SYNC_CMP) ? 32'(sync_cmp) : 32'h00000000;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_full <= 1'b0;
            w_full <= 1'b0;
            aw_addr <= '0;
            w_data <= '0;
            w_strb <= '0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && !aw_full)
            begin
                aw_full <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && !w_full)
            begin
                w_full <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (do_write)
            begin
                aw_full <= 1'b0;
                w_full <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
            end
            else if (s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    wire [31:0] wr_ctrl0 = merge({{(32-CTRL0_W){1'b0}}, ctrl0}, w_data, w_strb);
    wire [31:0] wr_ctrl1 = merge({24'h000000, edge_target, 4'h0}, w_data, w_strb);
    wire [31:0] wr_mask = merge({{(32-ST_W){1'b0}}, mask}, w_data, w_strb);
    wire [31:0] wr_brk = merge(32'(brk_cmp), w_data, w_strb);
    wire [31:0] wr_scmp = merge(32'(sync_cmp), w_data, w_strb);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ctrl0 <= CTRL0_RST;
            edge_target <= CTRL1_RST;
            mask <= '0;
            brk_cmp <= '0;
            sync_cmp <= '0;
        end
        else if (do_write)
        begin
            if (aw_addr == OFS_CTRL0)
                ctrl0 <= wr_ctrl0[CTRL0_W-1:0];
            if (aw_addr == OFS_CTRL1)
                edge_target <= wr_ctrl1[7:4];
            if (aw_addr == OFS_MASK)
                mask <= wr_mask[ST_W-1:0];
            if (aw_addr == OFS_BRK_TMR)
                brk_cmp <= wr_brk[TMR_BITS-1:0];
            if (aw_addr == OFS_SYNC_CMP)
                sync_cmp <= wr_scmp[TMR_BITS-1:0];
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end
        else if (rd_take)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_mux;
            s_axi_rresp <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

    // sticky status: read clears, a same-cycle event still wins
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            status <= '0;
        else
            status <= (rd_status ? '0 : status) | events;
    end

    assign irq = |(status & mask);

    a_rise_break: assert property (@(posedge aclk) disable iff (!aresetn)
        rise_brk_ev |=> status[ST_BRK]) else $error("rising edge did not set break status");
    a_no_rise_lin: assert property (@(posedge aclk) disable iff (!aresetn)
        (line.rise && !ctrl0.bus_mode) |-> !rise_brk_ev) else $error("lin rise gave break");

    sequence s_low_run;
        brk_start ##1 (!line.rise && active) [*3];
    endsequence
    a_brk_counts: assert property (@(posedge aclk) disable iff (!aresetn)
        s_low_run |-> brk_val == TMR_BITS'(2)) else $error("break timer not counting from fall");
    a_brk_stops: assert property (@(posedge aclk) disable iff (!aresetn)
        (line.rise && !brk_start) |=> !brk_run ##1 $stable(brk_val)) else $error("break timer kept counting");
    a_brk_match: assert property (@(posedge aclk) disable iff (!aresetn)
        brk_hit |=> status[ST_BRK] && brk_val == brk_cmp) else $error("break compare not flagged");
    a_cmp_gated: assert property (@(posedge aclk) disable iff (!aresetn)
        (!ctrl0.cmp_en && !status[ST_CMP] && !rd_status) |=> !status[ST_CMP])
        else $error("compare status set while disabled");
    a_cmp_set: assert property (@(posedge aclk) disable iff (!aresetn)
        (ctrl0.cmp_en && sync_tick && sync_inc == sync_cmp) |=> status[ST_CMP] && sync_val == sync_cmp)
        else $error("compare status missing");
    a_rx_gated: assert property (@(posedge aclk) disable iff (!aresetn)
        (lin_mode && ctrl0.gate && lin_st != LBSC_DATA) |=> uart_rxd) else $error("uart input not held");
    a_rx_pass: assert property (@(posedge aclk) disable iff (!aresetn)
        (lin_mode && !ctrl0.gate) |=> uart_rxd == $past(line_lvl)) else $error("uart input not passed");
    a_sync_edge: assert property (@(posedge aclk) disable iff (!aresetn)
        sync_stop |-> (ctrl0.stop_on_rise ? line.rise : line.fall)) else $error("sync stopped on wrong edge");
endmodule // lbsc_top

// ---- tb/lbsc_node_model.sv ----
/*
 far-side bus node: drives low pulses on the raw pin.
 assumes: pin has a pull-up, so a released pin reads high.
*/
module lbsc_node_model (
    input wire logic aclk,
    output logic bus_rx
);
    timeunit 1ns;
    timeprecision 1ps;
    initial bus_rx = 1'b1;
    // released pin returns high, so a mode switch after this is safe
    task automatic pulse(input int lo, input int hi);
        bus_rx <= 1'b0;
        repeat (lo) @(posedge aclk);
        bus_rx <= 1'b1;
        repeat (hi) @(posedge aclk);
    endtask
endmodule // lbsc_node_model

// ---- tb/lbsc_top_tb.sv ----
/*
 bench of the sync control block: axi master tasks, scenarios, verdict.
 assumes: node model on the pin, timers cut to 8 bits.
*/
module lbsc_top_tb_top
    import lbsc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk;
    logic aresetn = 1'b0;
    logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic bus_rx, uart_rxd, irq;
    logic watch = 1'b0, saw_low = 1'b0;
    int error_cnt = 0, n_checks = 0;

    lbsc_top #(.TMR_BITS(8)) DUT (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .bus_rx(bus_rx), .uart_rxd(uart_rxd), .irq(irq)
    );
    lbsc_node_model node (.aclk(aclk), .bus_rx(bus_rx));

    initial
    begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    // uart line watch: notes any low on uart_rxd while watch is set
    always @(posedge aclk)
    begin
        if (watch && uart_rxd !== 1'b1)
            saw_low <= 1'b1;
    end

    task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e)
        begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", w, e, g);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OKAY);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        chk("bresp", er, s_axi_bresp);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er = RESP_OKAY);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        d = s_axi_rdata;
        chk("rresp", er, s_axi_rresp);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string w);
        logic [31:0] v;
        rd(a, v);
        chk(w, e, v);
    endtask

    task automatic s_reset();
        logic [31:0] v;
        chk("uart idle", 1, uart_rxd);
        chk("irq idle", 0, irq);
        rdc(OFS_CTRL0, 0, "ctrl0 reset");
        rdc(OFS_STATUS, 0, "status reset");
        rd(8'h1C, v, RESP_SLVERR);
        chk("unmapped", 0, v);
        wr(8'h1C, 32'h0000_00FF, RESP_SLVERR);
        wr(OFS_CTRL0, 32'h0000_21E4);
        rdc(OFS_CTRL0, 32'h0000_21E4, "ctrl0");
    endtask

    task automatic s_write();
        logic [31:0] v;
        wr(OFS_CTRL0, 32'h0000_2064);
        wr(OFS_BRK_TMR, 32'h0000_00FF);
        wr(OFS_SYNC_CMP, 32'h0000_000C);
        wr(OFS_MASK, 32'h0000_0008);
        rd(OFS_STATUS, v);
        node.pulse(10, 40);
        chk("cmp irq", 1, irq);
        rdc(OFS_STATUS, 32'h0000_0008, "cmp status");
        rd(OFS_BRK_TMR, v);
        chk("tx width", 1, v >= 9 && v <= 11);
        // compare gate off: timer wraps past 12 unseen
        wr(OFS_CTRL0, 32'h0000_2044);
        rd(OFS_STATUS, v);
        node.pulse(10, 300);
        rdc(OFS_STATUS, 0, "cmp off");
    endtask

    task automatic s_read();
        logic [31:0] v;
        wr(OFS_CTRL0, 32'h0000_0144);
        wr(OFS_MASK, 32'h0000_0001);
        rd(OFS_STATUS, v);
        node.pulse(10, 8);
        chk("brk irq", 1, irq);
        rd(OFS_BRK_TMR, v);
        chk("rx width", 1, v >= 9 && v <= 11);
        rdc(OFS_BRK_TMR, v, "held");
        wr(OFS_MASK, 0);
        chk("masked", 0, irq);
        rdc(OFS_STATUS, 32'h0000_0001, "brk status");
        rdc(OFS_STATUS, 0, "read clear");
        wr(OFS_CTRL0, 32'h0000_0044);
        wr(OFS_BRK_TMR, 32'h0000_0014);
        node.pulse(10, 8);
        rdc(OFS_STATUS, 0, "gate off");
        node.pulse(30, 8);
        rdc(OFS_STATUS, 32'h0000_0001, "brk cmp");
        node.pulse(300, 8);
        rd(OFS_STATUS, v);
        chk("overflow", 1, v[ST_OVF]);
    endtask

    task automatic s_lin();
        logic [31:0] v;
        // disabling stops a sync timer left running by the bus scenarios
        wr(OFS_CTRL0, 32'h0000_0000);
        wr(OFS_CTRL0, 32'h0000_0104);
        wr(OFS_CTRL1, 32'h0000_0040);
        wr(OFS_BRK_TMR, 32'h0000_0014);
        rd(OFS_STATUS, v);
        watch <= 1'b1;
        node.pulse(30, 10);
        repeat (3) node.pulse(4, 4);
        watch <= 1'b0;
        chk("gated", 0, saw_low);
        repeat (3) node.pulse(4, 4);
        rd(OFS_STATUS, v);
        chk("sync done", 1, v[ST_SYNC]);
        saw_low <= 1'b0;
        watch <= 1'b1;
        node.pulse(6, 6);
        watch <= 1'b0;
        chk("data passes", 1, saw_low);
        wr(OFS_CTRL0, 32'h0000_0004);
        saw_low <= 1'b0;
        watch <= 1'b1;
        node.pulse(6, 6);
        watch <= 1'b0;
        chk("ungated", 1, saw_low);
    endtask

    task automatic s_rise_stop();
        logic [31:0] v;
        wr(OFS_CTRL0, 32'h0000_0184);
        node.pulse(30, 10);
        repeat (3) node.pulse(4, 4);
        rd(OFS_STATUS, v);
        chk("rise early", 0, v[ST_SYNC]);
        node.pulse(4, 4);
        rd(OFS_STATUS, v);
        chk("rise stop", 1, v[ST_SYNC]);
    endtask

    task automatic report_and_stop();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial
    begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        s_reset();
        s_write();
        s_read();
        s_lin();
        s_rise_stop();
        report_and_stop();
    end

    // tests need about 1.1k cycles; 200us timeout is 20k cycles, ample margin
    initial
    begin
        #200us;
        error_cnt++;
        report_and_stop();
    end
endmodule // lbsc_top_tb_top
